//--- hdl/dphyt_defs.svh
`ifndef DPHYT_DEFS_SVH
`define DPHYT_DEFS_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define DPHYT_IDX_CLK_ZERO 10'h041
`define DPHYT_IDX_CLK_TRAIL 10'h042
`define DPHYT_IDX_CLK_POST 10'h043
`define DPHYT_IDX_DATA_PREPARE 10'h044
`define DPHYT_IDX_DATA_ZERO 10'h045
`define DPHYT_IDX_DATA_TRAIL 10'h046
`define DPHYT_IDX_LANE_RATE 10'h030
`define DPHYT_NUM_TIMING 6

// ****************************************
// Field layout
// ****************************************
`define DPHYT_OVR_BIT 7
`define DPHYT_VAL_W 7
`define DPHYT_RATE_W 3

// ****************************************
// Reset values of the value fields (800 Mbps)
// ****************************************
`define DPHYT_RST_CLK_ZERO 7'h1b
`define DPHYT_RST_CLK_TRAIL 7'h0b
`define DPHYT_RST_CLK_POST 7'h0a
`define DPHYT_RST_DATA_PREPARE 7'h06
`define DPHYT_RST_DATA_ZERO 7'h0c
`define DPHYT_RST_DATA_TRAIL 7'h08
`define DPHYT_RST_LANE_RATE 3'h1

// ****************************************
// Lane rates in Mbps, for scaling
// ****************************************
`define DPHYT_MBPS_400 11'h190
`define DPHYT_MBPS_800 11'h320
`define DPHYT_MBPS_1200 11'h4b0
`define DPHYT_MBPS_1500 11'h5dc
`define DPHYT_MBPS_1600 11'h640
`define DPHYT_VAL_MAX 18'h0007f

`endif

//--- hdl/dphyt_pkg.sv
package dphyt_pkg;

    // Lane rate selections, in register encoding order
    typedef enum logic [2:0] {
        RATE_400,
        RATE_800,
        RATE_1200,
        RATE_1500,
        RATE_1600
    } dphyt_rate_t;

    // Six timing intervals handed to the transmitter
    typedef struct packed {
        logic [6:0] clk_zero;
        logic [6:0] clk_trail;
        logic [6:0] clk_post;
        logic [6:0] data_prepare;
        logic [6:0] data_zero;
        logic [6:0] data_trail;
    } dphyt_timing_t;

endpackage

//--- hdl/dphyt_auto_calc.sv
`timescale 1ns/10ps
`include "dphyt_defs.svh"

module dphyt_auto_calc (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] rate_sel,
    output dphyt_pkg::dphyt_timing_t auto_q
);

    // ****************************************
    // Rate scaling
    // ****************************************

    logic [10:0] mbps;
    dphyt_pkg::dphyt_timing_t auto_d;

    // Unknown codes fall back to 800 Mbps so intervals stay sane
    always_comb begin
        case (rate_sel)
            3'h0: mbps = `DPHYT_MBPS_400;
            3'h2: mbps = `DPHYT_MBPS_1200;
            3'h3: mbps = `DPHYT_MBPS_1500;
            3'h4: mbps = `DPHYT_MBPS_1600;
            default: mbps = `DPHYT_MBPS_800;
        endcase
    end

    // Intervals are in byte clocks, so they grow with the rate
    function automatic logic [6:0] scale(input logic [6:0] base, input logic [10:0] rate);
        logic [17:0] prod;
        logic [17:0] quot;
        prod = base * rate + 18'h00190;
        quot = prod / 18'h00320;
        if (quot > `DPHYT_VAL_MAX) begin
            scale = 7'h7f;
        end else begin
            scale = quot[6:0];
        end
    endfunction

    always_comb begin
        auto_d.clk_zero = scale(`DPHYT_RST_CLK_ZERO, mbps);
        auto_d.clk_trail = scale(`DPHYT_RST_CLK_TRAIL, mbps);
        auto_d.clk_post = scale(`DPHYT_RST_CLK_POST, mbps);
        auto_d.data_prepare = scale(`DPHYT_RST_DATA_PREPARE, mbps);
        auto_d.data_zero = scale(`DPHYT_RST_DATA_ZERO, mbps);
        auto_d.data_trail = scale(`DPHYT_RST_DATA_TRAIL, mbps);
    end

    // Recomputed every cycle; follows a rate change one edge later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_q <= {`DPHYT_RST_CLK_ZERO, `DPHYT_RST_CLK_TRAIL, `DPHYT_RST_CLK_POST,
                       `DPHYT_RST_DATA_PREPARE, `DPHYT_RST_DATA_ZERO, `DPHYT_RST_DATA_TRAIL};
        end else begin
            auto_q <= auto_d;
        end
    end

endmodule

//--- hdl/dphyt_field.sv
`timescale 1ns/10ps
`include "dphyt_defs.svh"

module dphyt_field #(
    parameter logic [6:0] RESET_VALUE = 7'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic [6:0] auto_val,
    output logic [7:0] rd_data,
    output logic [6:0] applied_q
);

    logic flag_q;
    logic [6:0] val_q;

    // Override flag always writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (wr_en) begin
            flag_q <= wr_data[`DPHYT_OVR_BIT];
        end
    end

    // Value only stored by a write that leaves override set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_q <= RESET_VALUE;
        end else if (wr_en && wr_data[`DPHYT_OVR_BIT]) begin
            val_q <= wr_data[6:0];
        end
    end

    // Read-back shows the interval in force
    assign rd_data = {flag_q, flag_q ? val_q : auto_val};

    // Source select for the transmitter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            applied_q <= RESET_VALUE;
        end else begin
            applied_q <= flag_q ? val_q : auto_val;
        end
    end

    a_auto_applied: assert property (@(posedge pclk) disable iff (!presetn)
        !flag_q |=> applied_q == $past(auto_val)) else $error("auto value not applied");
    a_ovr_applied: assert property (@(posedge pclk) disable iff (!presetn)
        flag_q |=> applied_q == $past(val_q)) else $error("override value not applied");
    a_ignored_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && !wr_data[7] |=> $stable(val_q) ##1 applied_q == $past(auto_val))
        else $error("write with flag clear changed timing");

endmodule

//--- hdl/dphyt_regs.sv
// Operation
// - Clock zero: bit 7 picks automatic or programmed; resets flag 0, value 0x1B
// - Clock trail: bit 7 picks automatic or programmed; resets to 0x0B
// - Clock post: bit 7 picks automatic or programmed; value resets 0xA
// - Data prepare: bit 7 picks automatic or programmed; value resets 0x6
// - Data zero: bit 7 picks automatic or programmed; resets to 0x0C
// - Data trail: bit 7 picks automatic or programmed; value resets 0x8
// - Flag clear: value field read-only, returns automatically computed interval in use
// - Flag set: value field read/write and drives the interval
// - Automatic values default to 800 Mbps, recomputed when lane rate changes
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`include "dphyt_defs.svh"

module dphyt_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output dphyt_pkg::dphyt_timing_t timing_q,
    output logic [2:0] lane_rate_q
);

    // ****************************************
    // Constants
    // ****************************************

    localparam int NT = `DPHYT_NUM_TIMING;
    localparam logic [41:0] RST_VEC = {`DPHYT_RST_CLK_ZERO, `DPHYT_RST_CLK_TRAIL,
        `DPHYT_RST_CLK_POST, `DPHYT_RST_DATA_PREPARE, `DPHYT_RST_DATA_ZERO,
        `DPHYT_RST_DATA_TRAIL};

    // ****************************************
    // APB handshake
    // ****************************************

    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic access;
    logic commit;
    logic [9:0] word_idx;
    logic aligned;
    logic hit_rate;
    logic [NT-1:0] hit_timing;
    logic mapped;

    // One wait state: answer in the second access cycle
    assign access = psel && penable && !pready_q;
    assign commit = psel && penable && pready_q;
    assign pready_d = access;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
        end
    end

    // ****************************************
    // Address decode
    // ****************************************

    // Upper address bits beyond the word index are not checked; only paddr[11:2] is decoded, with paddr[1:0] checked for alignment
    assign word_idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);

    always_comb begin
        hit_rate = 1'b0;
        hit_timing = '0;
        if (!aligned) begin
            hit_rate = 1'b0;
        end else if (word_idx == `DPHYT_IDX_LANE_RATE) begin
            hit_rate = 1'b1;
        end else if (word_idx == `DPHYT_IDX_CLK_ZERO) begin
            hit_timing[0] = 1'b1;
        end else if (word_idx == `DPHYT_IDX_CLK_TRAIL) begin
            hit_timing[1] = 1'b1;
        end else if (word_idx == `DPHYT_IDX_CLK_POST) begin
            hit_timing[2] = 1'b1;
        end else if (word_idx == `DPHYT_IDX_DATA_PREPARE) begin
            hit_timing[3] = 1'b1;
        end else if (word_idx == `DPHYT_IDX_DATA_ZERO) begin
            hit_timing[4] = 1'b1;
        end else if (word_idx == `DPHYT_IDX_DATA_TRAIL) begin
            hit_timing[5] = 1'b1;
        end
    end

    assign mapped = hit_rate || (|hit_timing);

    // Error flag rides with pready; unmapped writes change nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= access && !mapped;
        end
    end

    // ****************************************
    // Lane rate selection
    // ****************************************

    logic rate_we;
    logic rate_ok;

    // Codes past the last rate are refused so the stored code stays legal
    assign rate_ok = (pwdata[2:0] <= 3'(dphyt_pkg::RATE_1600));
    assign rate_we = commit && pwrite && pstrb[0] && hit_rate && rate_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_rate_q <= `DPHYT_RST_LANE_RATE;
        end else if (rate_we) begin
            lane_rate_q <= pwdata[2:0];
        end
    end

    // ****************************************
    // Automatic timing and the six registers
    // ****************************************

    dphyt_pkg::dphyt_timing_t auto_q;
    logic [41:0] auto_vec;
    logic [41:0] applied_vec;
    logic [NT*8-1:0] rd_vec;
    logic [NT-1:0] field_we;

    // Recompute on every rate change
    dphyt_auto_calc u_auto (
        .pclk(pclk),
        .presetn(presetn),
        .rate_sel(lane_rate_q),
        .auto_q(auto_q)
    );

    assign auto_vec = auto_q;

    // Index 0 is clock zero, the most significant slice of the struct
    for (genvar i = 0; i < NT; i++) begin : g_field
        assign field_we[i] = commit && pwrite && pstrb[0] && hit_timing[i];

        dphyt_field #(
            .RESET_VALUE(RST_VEC[(NT-1-i)*7 +: 7])
        ) u_field (
            .pclk(pclk),
            .presetn(presetn),
            .wr_en(field_we[i]),
            .wr_data(pwdata[7:0]),
            .auto_val(auto_vec[(NT-1-i)*7 +: 7]),
            .rd_data(rd_vec[i*8 +: 8]),
            .applied_q(applied_vec[(NT-1-i)*7 +: 7])
        );
    end

    assign timing_q = applied_vec;

    // ****************************************
    // Read data
    // ****************************************

    // Captured in the first access cycle, before any write lands
    always_comb begin
        prdata_d = 32'h00000000;
        if (hit_rate) begin
            prdata_d = {29'h00000000, lane_rate_q};
        end else begin
            for (int k = 0; k < NT; k++) begin
                if (hit_timing[k]) begin
                    prdata_d = {24'h000000, rd_vec[k*8 +: 8]};
                end
            end
        end
    end

    // Held between answers so the bus sees no glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (access && !pwrite) begin
            prdata_q <= prdata_d;
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // Checks
    // ****************************************

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic out_of_reset_q;

    // Marks the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_of_reset_q <= 1'b0;
        end else begin
            out_of_reset_q <= 1'b1;
        end
    end

    sequence s_first_cycle;
        !out_of_reset_q;
    endsequence

    sequence s_rate_800_settled;
        (lane_rate_q == 3'h1 && !rd_vec[7])[*3];
    endsequence

    sequence s_rate_1600_settled;
        (lane_rate_q == 3'h4 && !rd_vec[7])[*3];
    endsequence

    sequence s_write_flag_clear(int k);
        commit && pwrite && pstrb[0] && hit_timing[k] && !pwdata[7];
    endsequence

    a_clk_zero_rst: assert property (s_first_cycle |-> timing_q.clk_zero == 7'h1b && !rd_vec[7])
        else $error("clock zero reset wrong");
    a_clk_trail_rst: assert property (s_first_cycle |-> timing_q.clk_trail == 7'h0b && !rd_vec[15])
        else $error("clock trail reset wrong");
    a_clk_post_rst: assert property (s_first_cycle |-> timing_q.clk_post == 7'h0a && !rd_vec[23])
        else $error("clock post reset wrong");
    a_data_prep_rst: assert property (s_first_cycle |-> timing_q.data_prepare == 7'h06)
        else $error("data prepare reset wrong");
    a_data_zero_rst: assert property (s_first_cycle |-> rd_vec[39:32] == 8'h0c)
        else $error("data zero reset wrong");
    a_data_trail_rst: assert property (s_first_cycle |-> timing_q.data_trail == 7'h08)
        else $error("data trail reset wrong");

    a_rate_default: assert property (s_first_cycle |-> lane_rate_q == 3'h1)
        else $error("lane rate not 800 after reset");
    a_auto_at_800: assert property (s_rate_800_settled |-> timing_q.clk_zero == 7'h1b)
        else $error("auto clock zero wrong at 800");
    a_auto_at_1600: assert property (s_rate_1600_settled |-> timing_q.clk_zero == 7'h36)
        else $error("auto clock zero not recomputed at 1600");

    a_zero_override: assert property (
        commit && pwrite && pstrb[0] && hit_timing[0] && pwdata[7]
        |=> ##1 timing_q.clk_zero == $past(pwdata[6:0], 2)) else $error("clock zero override lost");
    a_trail_ignored: assert property (
        s_write_flag_clear(1) |=> rd_vec[14:8] == auto_q.clk_trail) else $error("trail write not ignored");

    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("answer not in second access cycle");
    a_apb_read: assert property (
        psel && penable && !pready && !pwrite && hit_timing[2] |=> prdata[7:0] == $past(rd_vec[23:16]))
        else $error("post register read-back wrong");

    // ****************************************
    // Refusals, answer shape and data overrides
    // ****************************************

    sequence s_rate_bad_write;
        commit && pwrite && pstrb[0] && hit_rate && (pwdata[2:0] > 3'(dphyt_pkg::RATE_1600));
    endsequence

    sequence s_override_write(int k);
        commit && pwrite && pstrb[0] && hit_timing[k] && pwdata[7];
    endsequence

    // A refused code must leave the stored rate legal and unchanged
    a_rate_refused: assert property (s_rate_bad_write |=> $stable(lane_rate_q))
        else $error("refused lane rate code was stored");
    a_rate_legal: assert property (lane_rate_q <= 3'(dphyt_pkg::RATE_1600))
        else $error("lane rate code out of range");

    // Error only rides with the answer, and only for holes in the map
    a_err_unmapped: assert property (access && !mapped |=> pready && pslverr)
        else $error("unmapped access not flagged");
    a_err_mapped: assert property (access && mapped |=> pready && !pslverr)
        else $error("mapped access flagged as error");
    a_ready_pulse: assert property (pready |=> !pready && !pslverr)
        else $error("answer held past one cycle");

    // Data-lane overrides reach the transmitter two edges after the write
    a_dzero_override: assert property (
        s_override_write(4) |=> ##1 timing_q.data_zero == $past(pwdata[6:0], 2))
        else $error("data zero override lost");
    a_trail_override: assert property (
        s_override_write(5) |=> ##1 timing_q.data_trail == $past(pwdata[6:0], 2))
        else $error("data trail override lost");

endmodule

//--- dv/dphyt_regs_tb_top.sv
`timescale 1ns/10ps

module dphyt_regs_tb_top;

    // ****************************************
    // Clock, reset and design hookup
    // ****************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    dphyt_pkg::dphyt_timing_t timing_q;
    logic [2:0] lane_rate_q;
    int failures = 0;
    int compares = 0;
    logic [6:0] rst_tab [6] = '{7'h1b, 7'h0b, 7'h0a, 7'h06, 7'h0c, 7'h08};
    int mbps_tab [5] = '{400, 800, 1200, 1500, 1600};
    logic [31:0] rd;
    logic err;
    logic [6:0] v;

    dphyt_regs #(.ADDR_W(12)) dphyt_regs_inst (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .timing_q(timing_q),
        .lane_rate_q(lane_rate_q)
    );

    // 50 ns period
    initial begin
        forever #25 pclk = ~pclk;
    end

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    // One APB transfer; waits on pready for as long as it takes, the watchdog ends a hang
    task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [7:0] data,
                            input logic [3:0] strb, output logic [31:0] rdat, output logic rerr);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h000000, data};
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    // Applied interval of register i, clock zero first
    function automatic logic [6:0] tfield(input int i);
        return timing_q[41 - 7 * i -: 7];
    endfunction

    // Rounded scaling from the 800 Mbps value, half rounds up
    function automatic logic [6:0] auto_val(input int i, input int code);
        int x;
        x = (int'(rst_tab[i]) * mbps_tab[code] + 400) / 800;
        if (x > 127) begin
            x = 127;
        end
        return x[6:0];
    endfunction

    // Settle time: timing_q follows a timing register write two edges late, a lane rate write three
    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hang short; the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        final_report();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset contents, flags clear, 800 Mbps values in use
        chk("lane_rate_q", 32'h1, {29'h0, lane_rate_q});
        for (int i = 0; i < 6; i++) begin
            apb_xfer(1'b0, 12'h104 + 12'(4 * i), 8'h00, 4'h0, rd, err);
            chk("reset read", {25'h0, rst_tab[i]}, rd);
            chk("reset applied", {25'h0, rst_tab[i]}, {25'h0, tfield(i)});
        end
        $display("test reset_values done");

        // Override on, then off again with a value that must not stick
        for (int i = 0; i < 6; i++) begin
            v = 7'h40 + 7'(i);
            apb_xfer(1'b1, 12'h104 + 12'(4 * i), {1'b1, v}, 4'h1, rd, err);
            settle();
            apb_xfer(1'b0, 12'h104 + 12'(4 * i), 8'h00, 4'h0, rd, err);
            chk("override read", {24'h0, 1'b1, v}, rd);
            chk("override applied", {25'h0, v}, {25'h0, tfield(i)});
            apb_xfer(1'b1, 12'h104 + 12'(4 * i), 8'h7f, 4'h1, rd, err);
            settle();
            apb_xfer(1'b0, 12'h104 + 12'(4 * i), 8'h00, 4'h0, rd, err);
            chk("auto read", {25'h0, rst_tab[i]}, rd);
            chk("auto applied", {25'h0, rst_tab[i]}, {25'h0, tfield(i)});
        end
        $display("test override done");

        // Every lane rate recomputes the automatic values
        for (int c = 0; c < 5; c++) begin
            apb_xfer(1'b1, 12'h0c0, 8'(c), 4'h1, rd, err);
            settle();
            chk("lane_rate_q", c, {29'h0, lane_rate_q});
            for (int i = 0; i < 6; i++) begin
                apb_xfer(1'b0, 12'h104 + 12'(4 * i), 8'h00, 4'h0, rd, err);
                chk("rate read", {25'h0, auto_val(i, c)}, rd);
                chk("rate applied", {25'h0, auto_val(i, c)}, {25'h0, tfield(i)});
            end
        end
        $display("test lane_rate done");

        // Refusals: out-of-range code, unmapped, misaligned, no strobe
        apb_xfer(1'b1, 12'h0c0, 8'h05, 4'h1, rd, err);
        settle();
        chk("rate kept", 32'h4, {29'h0, lane_rate_q});
        apb_xfer(1'b0, 12'h200, 8'h00, 4'h0, rd, err);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb_xfer(1'b0, 12'h105, 8'h00, 4'h0, rd, err);
        chk("misaligned err", 32'h1, {31'h0, err});
        apb_xfer(1'b1, 12'h104, 8'h85, 4'h0, rd, err);
        chk("no strobe err", 32'h0, {31'h0, err});
        settle();
        apb_xfer(1'b0, 12'h104, 8'h00, 4'h0, rd, err);
        chk("no strobe read", {25'h0, auto_val(0, 4)}, rd);
        $display("test refusals done");
        final_report();
    end

endmodule
